// ### rpi_edge_latch.v
// Sticky rise and fall edge latches with per-bit enables and clear on read
`timescale 1ns/1ps
module rpi_edge_latch #(
  parameter W = 8
) (
  input  wire         sys_clk,     // System clock
  input  wire         reset,       // Synchronous reset, active high
  input  wire [W-1:0] level,       // Watched levels, same clock
  input  wire [W-1:0] rise_en,     // Rising edge enables
  input  wire [W-1:0] fall_en,     // Falling edge enables
  input  wire         clear_rise,  // Clear rise latches, pulse
  input  wire         clear_fall,  // Clear fall latches, pulse
  output reg  [W-1:0] rise_latch,  // Latched rising edges
  output reg  [W-1:0] fall_latch   // Latched falling edges
);

  reg [W-1:0] prev_r;
  reg         primed_r;

  // No edge is seen on the first cycle after reset, so a level already high is not a rise
  wire [W-1:0] rise_hit = primed_r ? (level & ~prev_r & rise_en) : {W{1'b0}};
  wire [W-1:0] fall_hit = primed_r ? (~level & prev_r & fall_en) : {W{1'b0}};

  always @(posedge sys_clk) begin
    if (reset) begin
      prev_r     <= {W{1'b0}};
      primed_r   <= 1'b0;
      rise_latch <= {W{1'b0}};
      fall_latch <= {W{1'b0}};
    end else begin
      prev_r     <= level;
      primed_r   <= 1'b1;
      // Set wins over a clear in the same cycle
      rise_latch <= (rise_latch & ~{W{clear_rise}}) | rise_hit;
      fall_latch <= (fall_latch & ~{W{clear_fall}}) | fall_hit;
    end
  end

endmodule

// ### rpi_host_model.sv
// Register host model: single-byte paged writes and reads
`timescale 1ns/1ps
module rpi_host_model (
  input  wire       sys_clk,    // Clock
  input  wire [7:0] reg_rdata,  // Read data
  input  wire       reg_rvalid, // Read valid
  output reg  [7:0] reg_addr,   // Offset
  output reg  [7:0] reg_wdata,  // Write data
  output reg        reg_wr,     // Write strobe
  output reg        reg_rd      // Read strobe
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // Idle bus shows inverted values so a stale offset is never mistaken
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(negedge sys_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge sys_clk);
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
    end
  endtask
  task rd(input [7:0] a, output [7:0] d, output v);
    begin
      @(negedge sys_clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge sys_clk);
      reg_rd = 1'b0;
      reg_addr = ~a;
      d = reg_rdata;
      v = reg_rvalid;
    end
  endtask
endmodule

// ### rpi_port_events.v
// Per-port sticky event status byte with two read-clear groups
`timescale 1ns/1ps
`include "rpi_regs.vh"
module rpi_port_events (
  input  wire       sys_clk,              // System clock
  input  wire       reset,                // Synchronous reset, active high
  input  wire       line_length_changed,  // Line length change pulse
  input  wire       line_total_changed,   // Lines per frame change pulse
  input  wire       overflow_flag,        // Receive buffer overflow pulse
  input  wire       link_parity_error,    // Link parity error pulse
  input  wire       port_valid,           // Port valid level
  input  wire       lock_state,           // Link lock level
  input  wire       clear_one,            // First status register read, pulse
  input  wire       clear_two,            // Second status register read, pulse
  output reg  [7:0] event_bits            // Latched event status
);

  reg prev_valid_r;
  reg prev_lock_r;
  reg primed_r;

  wire valid_chg = primed_r & (port_valid ^ prev_valid_r);
  wire lock_chg  = primed_r & (lock_state ^ prev_lock_r);

  reg [7:0] set_v;
  reg [7:0] clr_v;

  always @* begin
    set_v = `RPI_RST_BYTE;
    clr_v = `RPI_RST_BYTE;
    set_v[`RPI_BIT_LINE_LEN]   = line_length_changed;
    set_v[`RPI_BIT_LINE_TOT]   = line_total_changed;
    set_v[`RPI_BIT_OVERFLOW]   = overflow_flag;
    set_v[`RPI_BIT_PARITY]     = link_parity_error;
    set_v[`RPI_BIT_PORT_VALID] = valid_chg;
    set_v[`RPI_BIT_LOCK]       = lock_chg;
    clr_v[`RPI_BIT_LINE_LEN]   = clear_two;
    clr_v[`RPI_BIT_LINE_TOT]   = clear_two;
    clr_v[`RPI_BIT_OVERFLOW]   = clear_two;
    clr_v[`RPI_BIT_PARITY]     = clear_one;
    clr_v[`RPI_BIT_PORT_VALID] = clear_one;
    clr_v[`RPI_BIT_LOCK]       = clear_one;
  end

  always @(posedge sys_clk) begin
    if (reset) begin
      prev_valid_r <= 1'b0;
      prev_lock_r  <= 1'b0;
      primed_r     <= 1'b0;
      event_bits   <= `RPI_RST_BYTE;
    end else begin
      prev_valid_r <= port_valid;
      prev_lock_r  <= lock_state;
      primed_r     <= 1'b1;
      // Set wins over clear; reserved bits forced low
      event_bits   <= ((event_bits & ~clr_v) | set_v) & `RPI_EVT_USED_MASK;
    end
  end

endmodule

// ### rpi_regs.vh
// Register offsets, field positions, reset values for the receive-port event block
`ifndef RPI_REGS_VH
`define RPI_REGS_VH

`define RPI_ADDR_PORT_SEL   8'h4C
`define RPI_ADDR_EVT_EN     8'hD9
`define RPI_ADDR_EVT_STS    8'hDB
`define RPI_ADDR_GPIO_STS   8'hDC
`define RPI_ADDR_GPIO_EN    8'hDD
`define RPI_ADDR_SEN_RISE   8'hDE
`define RPI_ADDR_SEN_FALL   8'hDF
`define RPI_ADDR_ID0        8'hF0

`define RPI_BIT_LINE_LEN    6
`define RPI_BIT_LINE_TOT    5
`define RPI_BIT_OVERFLOW    4
`define RPI_BIT_PARITY      2
`define RPI_BIT_PORT_VALID  1
`define RPI_BIT_LOCK        0

`define RPI_EVT_USED_MASK   8'h77
`define RPI_RST_BYTE        8'h00
`define RPI_RD_ZERO         8'h00

`define RPI_PSEL_W          2
`define RPI_RST_PSEL        2'h0

// Arbitrary identification value, not tied to any real part
`define RPI_ID0_VALUE       8'hA7

`endif

// ### rpi_top.v
// Receive-port event status block: paged per-port latches, enables, identity byte
//
// Operation
// - Line length change sets status bit 6; reading second status register clears it.
// - Lines per frame change sets status bit 5; second status read clears it.
// - Buffer overflow sets status bit 4; second status read clears it.
// - Link parity error sets status bit 2; first status read clears it.
// - Port valid change sets status bit 1; first status read clears it.
// - Lock change sets status bit 0; first status read clears it.
// - GPIO status bits 7..4 latch GPIO 3..0 events; reading register clears them.
// - GPIO status bits 3..0 show current forward GPIO 3..0 levels.
// - Odd GPIO enable bits 7,5,3,1 enable falling edge for GPIO 3..0.
// - Even GPIO enable bits 6,4,2,0 enable rising edge for GPIO 3..0.
// - Enabled rising sensor transitions latch in rise status; read clears.
// - Enabled falling sensor transitions latch in fall status; read clears.
// - Enable and status registers exist per port; port select register picks the accessed copy.
// - Read-only identity byte returns a fixed value on every read.
// - An event status bit interrupts only when its enable bit is set; latched GPIO and sensor bits always interrupt.
`timescale 1ns/1ps
`include "rpi_regs.vh"
module rpi_top #(
  parameter       NPORTS = 4,
  parameter [7:0] ID0    = `RPI_ID0_VALUE  // Arbitrary value
) (
  input  wire                  sys_clk,             // System clock, 125 MHz
  input  wire                  reset,               // Synchronous reset, active high
  input  wire [7:0]            reg_addr,            // Register offset
  input  wire [7:0]            reg_wdata,           // Write data
  input  wire                  reg_wr,              // Write strobe, pulse
  input  wire                  reg_rd,              // Read strobe, pulse
  output reg  [7:0]            reg_rdata,           // Read data
  output reg                   reg_rvalid,          // Read data valid, pulse
  output wire [`RPI_PSEL_W-1:0] port_page,          // Selected port
  input  wire [NPORTS-1:0]     line_length_changed, // Per-port pulses
  input  wire [NPORTS-1:0]     line_total_changed,  // Per-port pulses
  input  wire [NPORTS-1:0]     overflow_flag,       // Per-port pulses
  input  wire [NPORTS-1:0]     link_parity_error,   // Per-port pulses
  input  wire [NPORTS-1:0]     port_valid,          // Per-port levels
  input  wire [NPORTS-1:0]     lock_state,          // Per-port levels
  input  wire [NPORTS-1:0]     rx_status_one_rd,    // First status read, per port
  input  wire [NPORTS-1:0]     rx_status_two_rd,    // Second status read, per port
  input  wire [NPORTS*4-1:0]   fwd_pin_levels,      // Forward GPIO levels, 4 per port
  input  wire [NPORTS*8-1:0]   sensor_state_bits,   // Sensor status, 8 per port
  input  wire [NPORTS*8-1:0]   sensor_rise_select,  // Rise masks, 8 per port
  input  wire [NPORTS*8-1:0]   sensor_fall_select,  // Fall masks, 8 per port
  output reg  [NPORTS-1:0]     port_irq             // Per-port request
);

  function addr_is;
    input [7:0] a;
    input [7:0] target;
    begin
      addr_is = (a == target);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Port select

  reg [`RPI_PSEL_W-1:0] port_sel_r;

  always @(posedge sys_clk) begin
    if (reset) begin
      port_sel_r <= `RPI_RST_PSEL;
    end else if (reg_wr && addr_is(reg_addr, `RPI_ADDR_PORT_SEL)) begin
      port_sel_r <= reg_wdata[`RPI_PSEL_W-1:0];
    end
  end

  assign port_page = port_sel_r;

  ////////////////////////////////////////////////////////////////////////////
  // Per-port copies

  wire [NPORTS*8-1:0] evt_flat;
  wire [NPORTS*8-1:0] en_flat;
  wire [NPORTS*8-1:0] gpio_flat;
  wire [NPORTS*8-1:0] rise_flat;
  wire [NPORTS*8-1:0] fall_flat;
  wire [NPORTS-1:0]   irq_nxt;

  genvar p;
  generate
    for (p = 0; p < NPORTS; p = p + 1) begin : g_port
      wire       sel_p = ({{(32-`RPI_PSEL_W){1'b0}}, port_sel_r} == p);
      wire       rd_p  = reg_rd & sel_p;
      wire       wr_p  = reg_wr & sel_p;
      reg  [7:0] evt_en_r;
      reg  [7:0] gpio_en_r;
      wire [7:0] evt_bits;
      wire [3:0] gpio_rise;
      wire [3:0] gpio_fall;
      wire [7:0] sen_rise;
      wire [7:0] sen_fall;

      always @(posedge sys_clk) begin
        if (reset) begin
          evt_en_r  <= `RPI_RST_BYTE;
          gpio_en_r <= `RPI_RST_BYTE;
        end else begin
          if (wr_p && addr_is(reg_addr, `RPI_ADDR_EVT_EN)) begin
            evt_en_r <= reg_wdata & `RPI_EVT_USED_MASK;
          end
          if (wr_p && addr_is(reg_addr, `RPI_ADDR_GPIO_EN)) begin
            gpio_en_r <= reg_wdata;
          end
        end
      end

      rpi_port_events u_events (
        .sys_clk             (sys_clk),
        .reset               (reset),
        .line_length_changed (line_length_changed[p]),
        .line_total_changed  (line_total_changed[p]),
        .overflow_flag       (overflow_flag[p]),
        .link_parity_error   (link_parity_error[p]),
        .port_valid          (port_valid[p]),
        .lock_state          (lock_state[p]),
        .clear_one           (rx_status_one_rd[p]),
        .clear_two           (rx_status_two_rd[p]),
        .event_bits          (evt_bits)
      );

      // Enables interleave per pin: fall on odd bit, rise on even bit
      rpi_edge_latch #(.W(4)) u_gpio (
        .sys_clk    (sys_clk),
        .reset      (reset),
        .level      (fwd_pin_levels[p*4 +: 4]),
        .rise_en    ({gpio_en_r[6], gpio_en_r[4], gpio_en_r[2], gpio_en_r[0]}),
        .fall_en    ({gpio_en_r[7], gpio_en_r[5], gpio_en_r[3], gpio_en_r[1]}),
        .clear_rise (rd_p && addr_is(reg_addr, `RPI_ADDR_GPIO_STS)),
        .clear_fall (rd_p && addr_is(reg_addr, `RPI_ADDR_GPIO_STS)),
        .rise_latch (gpio_rise),
        .fall_latch (gpio_fall)
      );

      rpi_edge_latch #(.W(8)) u_sensor (
        .sys_clk    (sys_clk),
        .reset      (reset),
        .level      (sensor_state_bits[p*8 +: 8]),
        .rise_en    (sensor_rise_select[p*8 +: 8]),
        .fall_en    (sensor_fall_select[p*8 +: 8]),
        .clear_rise (rd_p && addr_is(reg_addr, `RPI_ADDR_SEN_RISE)),
        .clear_fall (rd_p && addr_is(reg_addr, `RPI_ADDR_SEN_FALL)),
        .rise_latch (sen_rise),
        .fall_latch (sen_fall)
      );

      assign evt_flat[p*8 +: 8]  = evt_bits;
      assign en_flat[p*8 +: 8]   = evt_en_r;
      assign gpio_flat[p*8 +: 8] = {gpio_rise | gpio_fall, fwd_pin_levels[p*4 +: 4]};
      assign rise_flat[p*8 +: 8] = sen_rise;
      assign fall_flat[p*8 +: 8] = sen_fall;
      // GPIO and sensor latches are already gated by their own enables
      assign irq_nxt[p] = (|(evt_bits & evt_en_r)) | (|gpio_rise) | (|gpio_fall)
                        | (|sen_rise) | (|sen_fall);
    end
  endgenerate

  always @(posedge sys_clk) begin
    if (reset) begin
      port_irq <= {NPORTS{1'b0}};
    end else begin
      port_irq <= irq_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path, data captured before the read-clear takes effect

  reg [7:0] rd_mux;

  always @* begin
    case (reg_addr)
      `RPI_ADDR_PORT_SEL: rd_mux = {{(8-`RPI_PSEL_W){1'b0}}, port_sel_r};
      `RPI_ADDR_EVT_EN:   rd_mux = en_flat[port_sel_r*8 +: 8];
      `RPI_ADDR_EVT_STS:  rd_mux = evt_flat[port_sel_r*8 +: 8];
      `RPI_ADDR_GPIO_STS: rd_mux = gpio_flat[port_sel_r*8 +: 8];
      `RPI_ADDR_SEN_RISE: rd_mux = rise_flat[port_sel_r*8 +: 8];
      `RPI_ADDR_SEN_FALL: rd_mux = fall_flat[port_sel_r*8 +: 8];
      `RPI_ADDR_ID0:      rd_mux = ID0;
      default:            rd_mux = `RPI_RD_ZERO;                  // Write-only and unmapped
    endcase
  end

  always @(posedge sys_clk) begin
    if (reset) begin
      reg_rdata  <= `RPI_RD_ZERO;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rd_mux;
      end
    end
  end

endmodule

// ### rpi_top_bench.sv
// Self-checking bench for the receive-port event block
`timescale 1ns/1ps
module rpi_top_bench;
  localparam       NP     = 4;
  localparam [7:0] ID_EXP = 8'h3C;  // Arbitrary identity value
  reg              sys_clk, reset;
  wire [7:0]       reg_addr, reg_wdata, reg_rdata;
  wire             reg_wr, reg_rd, reg_rvalid;
  wire [1:0]       port_page;
  wire [NP-1:0]    port_irq;
  reg  [NP-1:0]    line_length_changed, line_total_changed, overflow_flag, link_parity_error;
  reg  [NP-1:0]    port_valid, lock_state, rx_status_one_rd, rx_status_two_rd;
  reg  [NP*4-1:0]  fwd_pin_levels;
  reg  [NP*8-1:0]  sensor_state_bits, sensor_rise_select, sensor_fall_select;
  integer          errors, total_checks, i;
  reg  [7:0]       rdv;
  reg              vv;
  rpi_host_model host_u (.sys_clk(sys_clk), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
  rpi_top #(.NPORTS(NP), .ID0(ID_EXP)) dut_u (.sys_clk(sys_clk), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .port_page(port_page),
    .line_length_changed(line_length_changed), .line_total_changed(line_total_changed),
    .overflow_flag(overflow_flag), .link_parity_error(link_parity_error),
    .port_valid(port_valid), .lock_state(lock_state), .rx_status_one_rd(rx_status_one_rd),
    .rx_status_two_rd(rx_status_two_rd), .fwd_pin_levels(fwd_pin_levels),
    .sensor_state_bits(sensor_state_bits), .sensor_rise_select(sensor_rise_select),
    .sensor_fall_select(sensor_fall_select), .port_irq(port_irq));
  task check(input string what, input [7:0] seen, input [7:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task rd_chk(input string what, input [7:0] a, input [7:0] exp);
    begin
      host_u.rd(a, rdv, vv);
      check("read valid", {7'h00, vv}, 8'h01);
      check(what, rdv, exp);
    end
  endtask
  // Port 1 only; one-cycle pulse then idle
  task kick(input [1:0] k);
    begin
      @(negedge sys_clk);
      case (k)
        2'h0: overflow_flag = 4'h2;
        2'h1: link_parity_error = 4'h2;
        2'h2: rx_status_one_rd = 4'h2;
        default: rx_status_two_rd = 4'h2;
      endcase
      @(negedge sys_clk);
      {overflow_flag, link_parity_error, rx_status_one_rd, rx_status_two_rd} = 16'h0000;
      @(negedge sys_clk);
    end
  endtask
  task close_out;
    begin
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
        $display("SIMULATION PASSED");
      end else begin
        $display("SIMULATION FAILED");
      end
      $finish;
    end
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // Whole sequence needs well under a thousand cycles
  initial begin
    #40000;
    errors = errors + 1;
    close_out;
  end
  initial begin
    errors = 0;
    total_checks = 0;
    reset = 1'b1;
    {line_length_changed, line_total_changed, overflow_flag, link_parity_error} = 16'h0000;
    {port_valid, lock_state, rx_status_one_rd, rx_status_two_rd} = 16'h0000;
    fwd_pin_levels = 16'h0000;
    sensor_state_bits = 32'h0000_0000;
    sensor_rise_select = 32'h0000_0F00;
    sensor_fall_select = 32'h0000_F000;
    repeat (16) @(negedge sys_clk);
    reset = 1'b0;
    for (i = 0; i < 7; i = i + 1) rd_chk("reset value", 8'hD9 + i[7:0], 8'h00);
    rd_chk("identity", 8'hF0, ID_EXP);
    host_u.wr(8'hF0, 8'h00);
    rd_chk("identity after write", 8'hF0, ID_EXP);
    host_u.wr(8'h4C, 8'h01);
    rd_chk("port select", 8'h4C, 8'h01);
    check("port page", {6'h00, port_page}, 8'h01);
    @(negedge sys_clk);
    {line_length_changed, line_total_changed, overflow_flag, link_parity_error} = 16'h2222;
    {port_valid, lock_state} = 8'h22;
    @(negedge sys_clk);
    {line_length_changed, line_total_changed, overflow_flag, link_parity_error} = 16'h0000;
    @(negedge sys_clk);
    check("request disabled", {4'h0, port_irq}, 8'h00);
    rd_chk("event status", 8'hDB, 8'h77);
    host_u.wr(8'hDB, 8'hFF);
    rd_chk("status after write", 8'hDB, 8'h77);
    kick(2'h2);
    rd_chk("status after first clear", 8'hDB, 8'h70);
    kick(2'h3);
    rd_chk("status after second clear", 8'hDB, 8'h00);
    host_u.wr(8'hD9, 8'hFF);
    rd_chk("event enable", 8'hD9, 8'h77);
    kick(2'h0);
    check("request on overflow", {4'h0, port_irq}, 8'h02);
    kick(2'h3);
    check("request cleared", {4'h0, port_irq}, 8'h00);
    host_u.wr(8'hD9, 8'h10);
    kick(2'h1);
    check("masked parity request", {4'h0, port_irq}, 8'h00);
    kick(2'h2);
    // Overflow and its clear in one cycle: the set must win
    @(negedge sys_clk);
    {overflow_flag, rx_status_two_rd} = 8'h22;
    @(negedge sys_clk);
    {overflow_flag, rx_status_two_rd} = 8'h00;
    rd_chk("set beats clear", 8'hDB, 8'h10);
    kick(2'h3);
    host_u.wr(8'h4C, 8'h00);
    rd_chk("other port status", 8'hDB, 8'h00);
    host_u.wr(8'h4C, 8'h01);
    host_u.wr(8'hDD, 8'h81);
    @(negedge sys_clk);
    fwd_pin_levels[7:4] = 4'b1011;
    @(negedge sys_clk);
    fwd_pin_levels[7:4] = 4'b0011;
    @(negedge sys_clk);
    check("gpio request", {4'h0, port_irq}, 8'h02);
    rd_chk("gpio status", 8'hDC, 8'h93);
    rd_chk("gpio status reread", 8'hDC, 8'h03);
    check("gpio request cleared", {4'h0, port_irq}, 8'h00);
    rd_chk("gpio enable readback", 8'hDD, 8'h00);
    @(negedge sys_clk);
    sensor_state_bits[15:8] = 8'hFF;
    @(negedge sys_clk);
    sensor_state_bits[15:8] = 8'h00;
    @(negedge sys_clk);
    rd_chk("sensor rise", 8'hDE, 8'h0F);
    rd_chk("sensor rise reread", 8'hDE, 8'h00);
    rd_chk("sensor fall", 8'hDF, 8'hF0);
    rd_chk("sensor fall reread", 8'hDF, 8'h00);
    close_out;
  end
endmodule
bind rpi_top rpi_top_sva #(.NPORTS(NPORTS), .ID0(ID0)) chk_u (.sys_clk(sys_clk),
  .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .port_page(port_page),
  .fwd_pin_levels(fwd_pin_levels), .port_irq(port_irq));

// ### rpi_top_sva.sv
// Port-level assertions for the receive-port event block
`timescale 1ns/1ps
`include "rpi_regs.vh"
module rpi_top_sva #(
  parameter       NPORTS = 4,
  parameter [7:0] ID0    = 8'hA7
) (
  input wire                   sys_clk,        // Clock
  input wire                   reset,          // Sync reset
  input wire [7:0]             reg_addr,       // Offset
  input wire [7:0]             reg_wdata,      // Write data
  input wire                   reg_wr,         // Write strobe
  input wire                   reg_rd,         // Read strobe
  input wire [7:0]             reg_rdata,      // Read data
  input wire                   reg_rvalid,     // Read valid
  input wire [`RPI_PSEL_W-1:0] port_page,      // Selected port
  input wire [NPORTS*4-1:0]    fwd_pin_levels, // Forward levels
  input wire [NPORTS-1:0]      port_irq        // Requests
);
  wire [NPORTS*4-1:0] lv_shift = fwd_pin_levels >> (4 * port_page);
  wire [3:0]          cur_lv   = lv_shift[3:0];
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  a_read_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("read strobe not answered next cycle");
  a_answer_cause: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("read valid without a read");
  a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  a_id_fixed: assert property (reg_rd && reg_addr == 8'hF0 |=> reg_rdata == ID0)
    else $error("identity byte wrong");
  a_reserved_zero: assert property (reg_rd && reg_addr == 8'hDB
    |=> reg_rdata[7] == 1'b0 && reg_rdata[3] == 1'b0)
    else $error("reserved status bits not zero");
  a_enable_hidden: assert property (reg_rd && reg_addr == 8'hDD |=> reg_rdata == 8'h00)
    else $error("edge enable register readable");
  a_page_follows: assert property (reg_wr && reg_addr == 8'h4C
    |=> port_page == $past(reg_wdata[1:0]))
    else $error("port select not taken");
  a_pin_levels: assert property (reg_rd && reg_addr == 8'hDC && $stable(fwd_pin_levels)
    |=> reg_rdata[3:0] == $past(cur_lv))
    else $error("forward levels misreported");
  a_irq_reset_low: assert property ($fell(reset) |-> port_irq == {NPORTS{1'b0}})
    else $error("request active after reset");
  cover property (reg_rd && reg_addr == 8'hDB);
  cover property (reg_wr && reg_addr == 8'h4C);
  cover property (port_irq != {NPORTS{1'b0}});
endmodule
